// [crb_core.sv]
// How it works
// [RULE1] reset pin low disables every output
// [RULE2] reset pin leaves latch contents untouched
// [RULE3] first rank powers up arbitrary, no init
// [RULE4] host loads latches before first update
// [RULE5] serial pass rewrites every output's route
// [RULE6] after reset high, programming fully works
// [RULE7] broadcast writes one word everywhere, once
// [RULE8] host broadcasts with serial select low
// [RULE9] broadcast clocks all latches from write strobe
// [RULE10] broadcast ignores output select lines
// [RULE11] parallel strobe fall loads addressed latch
// [RULE12] top bit enables, low bits pick source
// [RULE13] update low passes first rank onward
// [RULE14] serial clock fall shifts one bit in
`timescale 1ns/1ps
`default_nettype none
module crb_core #(
	parameter int NUM_OUT = crb_pkg::NUM_OUT
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic out_reset_n_i,
	input wire logic write_n_i,
	input wire logic [3:0] output_select_i,
	input wire logic [4:0] route_word_i,
	input wire logic serial_parallel_select_i,
	input wire logic serial_clk_n_i,
	input wire logic serial_data_in_i,
	input wire logic update_n_i,
	input wire logic chip_select_n_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [NUM_OUT-1:0] out_enable_o,
	output logic [NUM_OUT*4-1:0] out_source_o
);
	localparam int WW = crb_pkg::WORD_W;
	localparam int CW = NUM_OUT * WW;

	// ==========================================================
	// pin synchronisation
	logic [crb_pkg::SYNC_W-1:0] pins_raw;
	logic [crb_pkg::SYNC_W-1:0] pins_s;
	assign pins_raw = {chip_select_n_i, update_n_i, serial_data_in_i,
		serial_clk_n_i, serial_parallel_select_i, route_word_i,
		output_select_i, write_n_i, out_reset_n_i};

	crb_sync #(
		.W(crb_pkg::SYNC_W),
		.RST_VAL(crb_pkg::SYNC_RST)
	) u_sync (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.async_i(pins_raw),
		.sync_o(pins_s)
	);

	wire rst_pin_s = pins_s[crb_pkg::P_RST];
	wire we_s = pins_s[crb_pkg::P_WE];
	wire [3:0] sel_s = pins_s[crb_pkg::P_SEL +: crb_pkg::SEL_W];
	wire [4:0] route_s = pins_s[crb_pkg::P_ROUTE +: WW];
	wire serpar_s = pins_s[crb_pkg::P_SERPAR];
	wire sdi_s = pins_s[crb_pkg::P_SDI];
	wire update_s = pins_s[crb_pkg::P_UPDATE];
	wire cs_s = pins_s[crb_pkg::P_CS];
	// deselect holds the serial clock in its idle high level
	wire sclk_s = pins_s[crb_pkg::P_SCLK] | cs_s;

	// ==========================================================
	// strobe edges
	logic we_prev_q;
	logic sclk_prev_q;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			we_prev_q <= 1'b1;
			sclk_prev_q <= 1'b1;
		end else begin
			we_prev_q <= we_s;
			sclk_prev_q <= sclk_s;
		end
	end

	wire we_fall = we_prev_q & ~we_s;
	wire sclk_fall = sclk_prev_q & ~sclk_s;
	wire shift_ev = sclk_fall & ~serpar_s; // RULE14
	wire par_ev = we_fall & serpar_s; // RULE11
	wire bcast_ev = we_fall & ~serpar_s; // RULE9
	wire update_on = ~update_s;

	// ==========================================================
	// first rank
	// no reset here: contents stay arbitrary until the host loads them
	logic [CW-1:0] first_q;
	logic [CW-1:0] wr_vec;
	logic [CW-1:0] first_d;

	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_word
			// broadcast does not look at the select lines
			wire hit = bcast_ev | (par_ev & (sel_s == 4'(g))); // RULE7 RULE10
			assign wr_vec[g*WW +: WW] = hit ? route_s
				: first_q[g*WW +: WW]; // RULE11
		end
	endgenerate

	// serial chain: output top word first, enable bit leading
	assign first_d = shift_ev ? {first_q[CW-2:0], sdi_s} : wr_vec; // RULE5

	always_ff @(posedge clock_i) begin
		first_q <= first_d; // RULE2 RULE3
	end

	// ==========================================================
	// second rank, transparent while update is low
	logic [CW-1:0] matrix_q;
	always_ff @(posedge clock_i) begin
		if (update_on) begin
			matrix_q <= first_q; // RULE13
		end
	end

	// ==========================================================
	// output stage
	logic [31:0] ctrl_q;
	logic [NUM_OUT-1:0] en_d;
	logic [NUM_OUT*4-1:0] src_d;
	wire allow_on = rst_pin_s & ~ctrl_q[crb_pkg::CTRL_FORCE_OFF]; // RULE1

	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_out
			assign en_d[g] = allow_on
				& matrix_q[g*WW + crb_pkg::ENABLE_BIT]; // RULE12
			// a disabled output shows no source at all
			assign src_d[g*4 +: 4] = en_d[g]
				? matrix_q[g*WW +: crb_pkg::SRC_W] : 4'h0; // RULE12
		end
	endgenerate

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_enable_o <= '0;
			out_source_o <= '0;
		end else begin
			out_enable_o <= en_d; // RULE1 RULE6
			out_source_o <= src_d;
		end
	end

	// ==========================================================
	// wishbone slave, one wait state
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire adr_ctrl = (wb_adr_i == crb_pkg::ADR_CTRL);
	wire adr_stat = (wb_adr_i == crb_pkg::ADR_STATUS);
	wire adr_route = (wb_adr_i >= crb_pkg::ADR_ROUTE0)
		& (wb_adr_i <= crb_pkg::ADR_ROUTE_LAST)
		& (wb_adr_i[1:0] == 2'h0);
	wire [3:0] route_idx = wb_adr_i[5:2] - crb_pkg::ROUTE_IDX_BASE;
	wire ctrl_wr = req & wb_we_i & adr_ctrl & wb_sel_i[0];

	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h00000000;
		if (adr_ctrl) begin
			rd_d = ctrl_q;
		end else if (adr_stat) begin
			rd_d[crb_pkg::ST_RST] = rst_pin_s;
			rd_d[crb_pkg::ST_SERPAR] = serpar_s;
			rd_d[crb_pkg::ST_UPDATE] = update_on;
			rd_d[crb_pkg::ST_CS] = ~cs_s;
		end else if (adr_route) begin
			rd_d[WW-1:0] = matrix_q[route_idx*WW +: WW];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= crb_pkg::CTRL_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			if (ctrl_wr) begin
				ctrl_q <= {31'h00000000, wb_dat_i[crb_pkg::CTRL_FORCE_OFF]};
			end
			wb_ack_o <= req;
			wb_dat_o <= req ? rd_d : 32'h00000000;
		end
	end

	// ==========================================================
	// assertions
	sequence s_wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_wb_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	property p_reset_off;
		@(posedge clock_i) disable iff (!arst_n_i)
		!rst_pin_s |=> (out_enable_o == '0);
	endproperty
	a_reset_off: assert property (p_reset_off) // RULE1
		else $error("output enabled while reset pin low");

	property p_reset_keeps;
		@(posedge clock_i) disable iff (!arst_n_i)
		(!rst_pin_s && !shift_ev && !we_fall) |=> $stable(first_q);
	endproperty
	a_reset_keeps: assert property (p_reset_keeps) // RULE2
		else $error("reset pin altered first rank");

	property p_shift;
		@(posedge clock_i) disable iff (!arst_n_i)
		shift_ev |=> (first_q == {$past(first_q[CW-2:0]), $past(sdi_s)});
	endproperty
	a_shift: assert property (p_shift) // RULE14
		else $error("serial shift wrong");

	property p_par_write;
		@(posedge clock_i) disable iff (!arst_n_i)
		(par_ev && rst_pin_s && sel_s < NUM_OUT)
		|=> (first_q[$past(sel_s)*WW +: WW] == $past(route_s));
	endproperty
	a_par_write: assert property (p_par_write) // RULE11
		else $error("parallel write missed");

	property p_bcast;
		@(posedge clock_i) disable iff (!arst_n_i)
		bcast_ev |=> (first_q == {NUM_OUT{$past(route_s)}});
	endproperty
	a_bcast: assert property (p_bcast) // RULE7
		else $error("broadcast did not fill all latches");

	property p_bcast_no_shift;
		@(posedge clock_i) disable iff (!arst_n_i)
		(bcast_ev && sclk_s) |=> (first_q[WW-1:0] == $past(route_s));
	endproperty
	a_bcast_no_shift: assert property (p_bcast_no_shift) // RULE9
		else $error("shift during broadcast");

	property p_update;
		@(posedge clock_i) disable iff (!arst_n_i)
		update_on |=> (matrix_q == $past(first_q));
	endproperty
	a_update: assert property (p_update) // RULE13
		else $error("second rank not transparent");

	property p_hold;
		@(posedge clock_i) disable iff (!arst_n_i)
		!update_on |=> $stable(matrix_q);
	endproperty
	a_hold: assert property (p_hold) // RULE13
		else $error("second rank moved while update high");

	property p_disabled_src;
		@(posedge clock_i) disable iff (!arst_n_i)
		!out_enable_o[0] |-> (out_source_o[3:0] == 4'h0);
	endproperty
	a_disabled_src: assert property (p_disabled_src) // RULE12
		else $error("disabled output shows a source");

	property p_enable_follows;
		@(posedge clock_i) disable iff (!arst_n_i)
		(rst_pin_s && !ctrl_q[crb_pkg::CTRL_FORCE_OFF]) |=>
		(out_enable_o[0] == $past(matrix_q[crb_pkg::ENABLE_BIT]));
	endproperty
	a_enable_follows: assert property (p_enable_follows) // RULE6
		else $error("enable bit not honoured");

	property p_wb;
		@(posedge clock_i) disable iff (!arst_n_i)
		s_wb_req |=> s_wb_ans;
	endproperty
	a_wb: assert property (p_wb)
		else $error("wishbone ack timing wrong");
endmodule : crb_core
`default_nettype wire

// [crb_pkg.sv]
`default_nettype none
package crb_pkg;
	// ==========================================================
	// matrix geometry
	localparam int NUM_OUT = 9;
	localparam int WORD_W = 5;
	localparam int SEL_W = 4;
	localparam int SRC_W = 4;
	localparam int ENABLE_BIT = 4;
	localparam int CHAIN_W = NUM_OUT * WORD_W;

	// ==========================================================
	// pin bundle layout after synchronisation
	localparam int SYNC_W = 16;
	localparam int P_RST = 0;
	localparam int P_WE = 1;
	localparam int P_SEL = 2;
	localparam int P_ROUTE = 6;
	localparam int P_SERPAR = 11;
	localparam int P_SCLK = 12;
	localparam int P_SDI = 13;
	localparam int P_UPDATE = 14;
	localparam int P_CS = 15;
	// idle pin levels, reset pin low so outputs start disabled
	localparam logic [15:0] SYNC_RST = 16'hD802;

	// ==========================================================
	// register map, byte addresses
	localparam int ADR_W = 8;
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_STATUS = 8'h04;
	localparam logic [7:0] ADR_ROUTE0 = 8'h10;
	localparam logic [7:0] ADR_ROUTE_LAST = 8'h30;
	localparam logic [3:0] ROUTE_IDX_BASE = 4'h4;
	localparam int CTRL_FORCE_OFF = 0;
	localparam int ST_RST = 0;
	localparam int ST_SERPAR = 1;
	localparam int ST_UPDATE = 2;
	localparam int ST_CS = 3;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
endpackage : crb_pkg
`default_nettype wire

// [crb_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module crb_sync #(
	parameter int W = 16,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// ==========================================================
	// two stages per bit
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clock_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					meta_q[g] <= RST_VAL[g];
					sync_q[g] <= RST_VAL[g];
				end else begin
					meta_q[g] <= async_i[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_q;
endmodule : crb_sync
`default_nettype wire

// [crb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module crb_host_model (
	input wire logic clock_i,
	output logic out_reset_n_o,
	output logic write_n_o,
	output logic [3:0] output_select_o,
	output logic [4:0] route_word_o,
	output logic serial_parallel_select_o,
	output logic serial_clk_n_o,
	output logic serial_data_in_o,
	output logic update_n_o,
	output logic chip_select_n_o
);
	// ==========================================================
	// pin levels at power-up
	initial begin
		out_reset_n_o = 1'b0;
		write_n_o = 1'b1;
		output_select_o = 4'h0;
		route_word_o = 5'h00;
		serial_parallel_select_o = 1'b1;
		serial_clk_n_o = 1'b1;
		serial_data_in_o = 1'b0;
		update_n_o = 1'b1;
		chip_select_n_o = 1'b1;
	end

	// ==========================================================
	// pin sequences, each level held past the synchroniser
	task settle;
		repeat (4) @(posedge clock_i);
	endtask : settle

	task pwrite(input logic [3:0] a, input logic [4:0] d, input logic par);
		@(posedge clock_i);
		output_select_o <= a;
		route_word_o <= d;
		serial_parallel_select_o <= par;
		serial_clk_n_o <= 1'b1;
		settle;
		write_n_o <= 1'b0;
		settle;
		write_n_o <= 1'b1;
		settle;
	endtask : pwrite

	task shift45(input logic [44:0] c);
		@(posedge clock_i);
		serial_parallel_select_o <= 1'b0;
		chip_select_n_o <= 1'b0;
		settle;
		for (int i = 44; i >= 0; i--) begin
			serial_data_in_o <= c[i];
			settle;
			serial_clk_n_o <= 1'b0;
			settle;
			serial_clk_n_o <= 1'b1;
			settle;
		end
		chip_select_n_o <= 1'b1;
		// stale data must not look meaningful
		serial_data_in_o <= ~c[0];
		settle;
	endtask : shift45

	task pins(input logic rst_n, input logic upd_n);
		@(posedge clock_i);
		out_reset_n_o <= rst_n;
		update_n_o <= upd_n;
		repeat (10) @(posedge clock_i);
	endtask : pins
endmodule : crb_host_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [31:0] q;
	logic [31:0] rdat;
	logic ack;
	logic [8:0] oen;
	logic [35:0] osrc;
	logic [35:0] es;
	logic [44:0] c;
	wire rst_n, wr_n, serpar, sclk_n, sdi, upd_n, cs_n;
	wire [3:0] osel;
	wire [4:0] rw;
	int error_cnt = 0;
	int checked = 0;

	always #12.5 clock_i = ~clock_i;

	crb_host_model u_host (.clock_i(clock_i), .out_reset_n_o(rst_n),
		.write_n_o(wr_n), .output_select_o(osel), .route_word_o(rw),
		.serial_parallel_select_o(serpar), .serial_clk_n_o(sclk_n),
		.serial_data_in_o(sdi), .update_n_o(upd_n), .chip_select_n_o(cs_n));

	crb_core u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.out_reset_n_i(rst_n), .write_n_i(wr_n), .output_select_i(osel),
		.route_word_i(rw), .serial_parallel_select_i(serpar),
		.serial_clk_n_i(sclk_n), .serial_data_in_i(sdi), .update_n_i(upd_n),
		.chip_select_n_i(cs_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .out_enable_o(oen), .out_source_o(osrc));

	// ==========================================================
	// shared tasks
	task chk(input string n, input logic [35:0] e, input logic [35:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clock_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clock_i);
	endtask : wb

	task close_out;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// ==========================================================
	// scenarios
	task t_broadcast;
		u_host.pwrite(4'h5, 5'h17, 1'b0);
		u_host.pins(1'b0, 1'b0);
		chk("enable_rst", 36'h0, 36'(oen));
		chk("source_rst", 36'h0, osrc);
		u_host.pins(1'b1, 1'b0);
		chk("enable_all", 36'h1FF, 36'(oen));
		chk("source_all", 36'h777777777, osrc);
		u_host.pins(1'b0, 1'b0);
		chk("enable_rst2", 36'h0, 36'(oen));
		u_host.pins(1'b1, 1'b0);
		chk("source_kept", 36'h777777777, osrc);
		$display("test broadcast done");
	endtask : t_broadcast

	task t_wb;
		wb(1'b0, crb_pkg::ADR_STATUS, 32'h0);
		chk("status", 36'h5, 36'(q));
		wb(1'b0, crb_pkg::ADR_ROUTE0 + 8'h0C, 32'h0);
		chk("route3", 36'h17, 36'(q));
		chk("dat_idle", 36'h0, 36'(rdat));
		wb(1'b1, crb_pkg::ADR_CTRL, 32'h1);
		repeat (4) @(posedge clock_i);
		chk("force_off", 36'h0, 36'(oen));
		wb(1'b0, crb_pkg::ADR_CTRL, 32'h0);
		chk("ctrl", 36'h1, 36'(q));
		wb(1'b1, crb_pkg::ADR_CTRL, 32'h0);
		wb(1'b0, 8'h80, 32'h0);
		chk("unmapped", 36'h0, 36'(q));
		$display("test wishbone done");
	endtask : t_wb

	task t_serial;
		for (int k = 0; k < 9; k++) begin
			c[5*k +: 5] = {1'b1, 4'(k + 3)};
			es[4*k +: 4] = 4'(k + 3);
		end
		u_host.pins(1'b1, 1'b1);
		u_host.shift45(c);
		chk("held", 36'h777777777, osrc);
		u_host.pins(1'b1, 1'b0);
		chk("ser_enable", 36'h1FF, 36'(oen));
		chk("ser_source", es, osrc);
		$display("test serial done");
	endtask : t_serial

	task t_parallel;
		u_host.pins(1'b1, 1'b1);
		u_host.pwrite(4'h2, 5'h1F, 1'b1);
		u_host.pwrite(4'h0, 5'h0A, 1'b1);
		chk("par_held", es, osrc);
		u_host.pins(1'b1, 1'b0);
		es[11:8] = 4'hF;
		es[3:0] = 4'h0;
		chk("par_enable", 36'h1FE, 36'(oen));
		chk("par_source", es, osrc);
		$display("test parallel done");
	endtask : t_parallel

	initial begin
		repeat (10) @(posedge clock_i);
		arst_n_i <= 1'b1;
		t_broadcast;
		t_wb;
		t_serial;
		t_parallel;
		close_out;
	end

	// hang guard, well beyond the serial pass
	initial begin
		repeat (6000) @(posedge clock_i);
		error_cnt++;
		close_out;
	end
endmodule : tb
`default_nettype wire
